// ===== logic/urfc_map.svh
// Register map, field positions and the scratch reset value for the UART feature control block.
// Assumes: included by the block's module; no other dependencies.
// Function
// R1: Delta CTS flag sets on any CTS change since last status read; interrupt if enabled.
// R2: Upper modem-line nibble selects 0..15 bit times of turn-around delay.
// R3: Turn-around delay field written only while enhanced write enable is set.
// R4: Transmit disable halts the shifter; queued bytes resume when cleared.
// R5: Software keeps transmit disable low while using immediate send.
// R6: Receive disable finishes a character in progress, then accepts no more.
// R7: Software clears receive disable only while receive line idles high.
// R8: Receive FIFO remains readable whether or not the receiver is disabled.
// R9: Transmit disable mode selects whether xon/xoff still go out.
// R10: Receive disable mode selects whether xon/xoff still get detected.
// R11: Eight-bit scratch register, reset value 0xff.
// R12: Trigger table select; tables A-C use next trigger level for flow control.
// R13: Auto RS-485 direction overrides automatic RTS/DTR flow control.
// R14: Handshake select picks RTS or DTR as the direction output.
// R15: Direction low after last stop bit; high when a byte is loaded.
// R16: Transmit interrupt on shifter empty in RS-485 mode, else holding empty.
// R17: Direction unchanged when only an xon/xoff is sent with FIFO empty.
// R18: Infrared receive polarity bit inverts the encoded input when set.
// R19: Hysteresis field applies only with table D; resets to zero.
// R20: Hysteresis code decodes to a fixed table of character counts.
// R21: Enhanced bits writable only with enhanced write enable; clear at reset.
// R22: Flow control deasserts high at upper level, reasserts low below lower level.
// R23: Turn-around counted in whole bit periods, restarted by a new byte.
`ifndef URFC_MAP_SVH
`define URFC_MAP_SVH
`define URFC_ADDR_LINE_TUNE 4'h0
`define URFC_ADDR_SCRATCH   4'h1
`define URFC_ADDR_FEATURE   4'h2
`define URFC_ADDR_ENH       4'h3
`define URFC_ADDR_MODEM_CTL 4'h4
`define URFC_ADDR_STATUS    4'h5
`define URFC_ADDR_LOWER_LVL 4'h6
`define URFC_SCRATCH_RST    8'hff
`define URFC_LT_DELAY_HI    7
`define URFC_LT_DELAY_LO    4
`define URFC_LT_TXDIS       3
`define URFC_LT_RXDIS       2
`define URFC_LT_TXMODE      1
`define URFC_LT_RXMODE      0
`define URFC_FC_TBL_HI      7
`define URFC_FC_TBL_LO      6
`define URFC_FC_RS485       5
`define URFC_FC_IRPOL       4
`define URFC_ENH_WREN       4
`define URFC_ENH_AUTORTS    6
`define URFC_MCR_SEL        2
`define URFC_IER_MSI        3
`endif

// ===== logic/urfc_pkg.sv
// Types shared by the UART feature control block.
// Assumes: compiled before the module.
package urfc_pkg;
  typedef enum logic [1:0] {URFC_TBL_A, URFC_TBL_B, URFC_TBL_C, URFC_TBL_D} urfc_tbl_e;
  typedef enum {URFC_DIR_RX, URFC_DIR_TX, URFC_DIR_WAIT} urfc_dir_e;
endpackage

// ===== logic/urfc_ctrl.sv
// UART channel feature control: modem line tuning, scratch, feature control, RS-485 direction.
// Assumes: one clock, baud tick from the channel's generator, FIFOs and shifters outside.
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "urfc_map.svh"
module urfc_ctrl
  import urfc_pkg::*;
#(
  parameter int unsigned LVL_W = 9
) (
  // Clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_rst,
  // Register port
  input  wire logic [3:0]       i_addr,
  input  wire logic [7:0]       i_wdata,
  input  wire logic             i_wr,
  input  wire logic             i_rd,
  output logic      [7:0]       o_rdata,
  // Pins
  input  wire logic             i_cts_n,
  input  wire logic             i_rx_ir,
  output logic                  o_rts_n,
  output logic                  o_dtr_n,
  // Channel status from the shifters and FIFOs
  input  wire logic             i_bit_tick,
  input  wire logic             i_tx_load,
  input  wire logic             i_tx_xchar,
  input  wire logic             i_tx_fifo_empty,
  input  wire logic             i_tsr_empty,
  input  wire logic             i_rx_busy,
  input  wire logic [LVL_W-1:0] i_rx_level,
  input  wire logic [LVL_W-1:0] i_rx_trigger,
  input  wire logic [LVL_W-1:0] i_next_up,
  input  wire logic [LVL_W-1:0] i_next_dn,
  // Controls to the shifters
  output logic                  o_tx_halt,
  output logic                  o_xchar_ok,
  output logic                  o_rx_accept,
  output logic                  o_rx_xchar_ok,
  output logic                  o_rx_ir,
  output logic                  o_tx_irq_src,
  output logic                  o_msi_irq
);

  // Registers
  logic [7:0] line_tune;
  logic [7:0] scratch_pad;
  logic [7:0] feature_control_reg;
  logic [7:0] enhanced_feature_reg;
  logic [7:0] modem_control_reg;
  logic [7:0] interrupt_enable_reg;
  logic       delta_cts;
  logic       xchar_pend;
  logic       rx_frame;
  logic       flow_hold;
  logic [3:0] turn_cnt;
  urfc_dir_e  dir_state;
  urfc_dir_e  next_dir_state;
  logic       cts_m;
  logic       cts_s;
  logic       cts_q;
  logic       ir_m;
  logic       ir_s;

  // Pin synchronisers; the first stage feeds only the second
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cts_m <= 1'b1;
      cts_s <= 1'b1;
      cts_q <= 1'b1;
      ir_m  <= 1'b0;
      ir_s  <= 1'b0;
    end else begin
      cts_m <= i_cts_n;
      cts_s <= cts_m;
      cts_q <= cts_s;
      ir_m  <= i_rx_ir;
      ir_s  <= ir_m;
    end
  end

  // Address decode
  wire wr_tune   = i_wr && (i_addr == `URFC_ADDR_LINE_TUNE);
  wire wr_spr    = i_wr && (i_addr == `URFC_ADDR_SCRATCH);
  wire wr_feature_control   = i_wr && (i_addr == `URFC_ADDR_FEATURE);
  wire wr_efr    = i_wr && (i_addr == `URFC_ADDR_ENH);
  wire wr_mcr    = i_wr && (i_addr == `URFC_ADDR_MODEM_CTL);
  wire rd_status = i_rd && (i_addr == `URFC_ADDR_STATUS);
  wire wr_ier    = i_wr && (i_addr == `URFC_ADDR_LOWER_LVL);
  wire enh_wren  = enhanced_feature_reg[`URFC_ENH_WREN];
  wire cts_edge  = cts_s ^ cts_q;

  // Enhanced-bit write gating: line tune bits 7:4, modem control and interrupt enable bits 7:5 only move while write enable is set
  wire [7:0] next_tune = enh_wren ? i_wdata : {line_tune[7:4], i_wdata[3:0]}; // R3 R21
  wire [7:0] next_mcr  = enh_wren ? i_wdata : {modem_control_reg[7:5], i_wdata[4:0]}; // R21
  wire [7:0] next_ier  = enh_wren ? i_wdata : {interrupt_enable_reg[7:5], i_wdata[4:0]}; // R21

  // Register writes
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      line_tune            <= 8'h00;
      scratch_pad          <= `URFC_SCRATCH_RST; // R11
      feature_control_reg  <= 8'h00; // R19
      enhanced_feature_reg <= 8'h00;
      modem_control_reg    <= 8'h00;
      interrupt_enable_reg <= 8'h00;
    end else begin
      if (wr_tune) line_tune <= next_tune;
      if (wr_spr) scratch_pad <= i_wdata; // R11
      if (wr_feature_control) feature_control_reg <= i_wdata; // R12 R18 R19
      if (wr_efr) enhanced_feature_reg <= i_wdata;
      if (wr_mcr) modem_control_reg <= next_mcr;
      if (wr_ier) interrupt_enable_reg <= next_ier;
    end
  end

  // Delta CTS: a change in the read cycle wins over the clear
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) delta_cts <= 1'b0;
    else if (cts_edge) delta_cts <= 1'b1; // R1
    else if (rd_status) delta_cts <= 1'b0;
  end
  assign o_msi_irq = delta_cts && interrupt_enable_reg[`URFC_IER_MSI]; // R1

  // Read data, one cycle later; unmapped reads give zero
  wire [7:0] status_word = {~cts_s, 6'h00, delta_cts};
  wire [7:0] rd_mux =
    (i_addr == `URFC_ADDR_SCRATCH)   ? scratch_pad :
    (i_addr == `URFC_ADDR_FEATURE)   ? feature_control_reg :
    (i_addr == `URFC_ADDR_ENH)       ? enhanced_feature_reg :
    (i_addr == `URFC_ADDR_MODEM_CTL) ? modem_control_reg :
    (i_addr == `URFC_ADDR_STATUS)    ? status_word :
    (i_addr == `URFC_ADDR_LOWER_LVL) ? interrupt_enable_reg : 8'h00;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) o_rdata <= 8'h00;
    else if (i_rd) o_rdata <= rd_mux;
    else o_rdata <= 8'h00;
  end

  // Transmit disable and flow-control character pass
  wire tx_dis = line_tune[`URFC_LT_TXDIS];
  wire rx_dis = line_tune[`URFC_LT_RXDIS];
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) xchar_pend <= 1'b0;
    else if (!tx_dis) xchar_pend <= i_tx_xchar;
    else if (!i_tx_xchar) xchar_pend <= 1'b0;
  end
  assign o_tx_halt  = tx_dis; // R4 R5
  assign o_xchar_ok = !tx_dis || line_tune[`URFC_LT_TXMODE] || xchar_pend; // R9

  // Receive disable: a frame in progress is allowed to finish
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) rx_frame <= 1'b0;
    else if (!i_rx_busy) rx_frame <= 1'b0;
    else if (!rx_dis) rx_frame <= 1'b1; // R6
  end
  // The frame flag lags busy by a cycle, so it only counts while busy still stands
  assign o_rx_accept   = !rx_dis || (rx_frame && i_rx_busy); // R6 R7 R8
  assign o_rx_xchar_ok = o_rx_accept || line_tune[`URFC_LT_RXMODE]; // R10
  assign o_rx_ir       = feature_control_reg[`URFC_FC_IRPOL] ? ~ir_s : ir_s; // R18

  // Hysteresis decode in characters
  function automatic logic [5:0] hyst(input logic [3:0] code);
    case (code)
      4'h0: hyst = 6'd0;
      4'h1: hyst = 6'd4;
      4'h2: hyst = 6'd6;
      4'h3: hyst = 6'd8;
      4'h4: hyst = 6'd8;
      4'h5: hyst = 6'd16;
      4'h6: hyst = 6'd24;
      4'h7: hyst = 6'd32;
      4'h8: hyst = 6'd40;
      4'h9: hyst = 6'd44;
      4'ha: hyst = 6'd48;
      4'hb: hyst = 6'd52;
      4'hc: hyst = 6'd12;
      4'hd: hyst = 6'd20;
      4'he: hyst = 6'd28;
      default: hyst = 6'd36;
    endcase // R20
  endfunction

  // Flow-control levels; table D with nonzero code uses hysteresis around the trigger
  wire             tbl_d   = feature_control_reg[7:6] == URFC_TBL_D;
  wire [5:0]       hv      = hyst(feature_control_reg[3:0]);
  wire             use_h   = tbl_d && (hv != 6'd0); // R19
  wire [LVL_W:0]   up_h    = {1'b0, i_rx_trigger} + {{(LVL_W-5){1'b0}}, hv};
  wire [LVL_W-1:0] up_lvl  = use_h ? up_h[LVL_W-1:0] : i_next_up; // R12
  wire [LVL_W-1:0] dn_lvl  = use_h ? (i_rx_trigger - {{(LVL_W-6){1'b0}}, hv}) : i_next_dn; // R12
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) flow_hold <= 1'b0;
    else if (i_rx_level >= up_lvl) flow_hold <= 1'b1; // R22
    else if (i_rx_level < dn_lvl) flow_hold <= 1'b0; // R22
  end

  // RS-485 direction: TX on load, wait turn-around after shifter drains
  wire rs485 = feature_control_reg[`URFC_FC_RS485];
  always_comb begin
    next_dir_state = dir_state;
    case (dir_state)
      URFC_DIR_RX: if (i_tx_load) next_dir_state = URFC_DIR_TX; // R15 R17
      URFC_DIR_TX: if (i_tsr_empty && i_tx_fifo_empty && !i_tx_load) next_dir_state = URFC_DIR_WAIT; // R15
      default: begin
        if (i_tx_load) next_dir_state = URFC_DIR_TX; // R23
        else if (turn_cnt == line_tune[7:4]) next_dir_state = URFC_DIR_RX; // R2
      end
    endcase
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) dir_state <= URFC_DIR_RX;
    else if (!rs485) dir_state <= URFC_DIR_RX;
    else dir_state <= next_dir_state;
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) turn_cnt <= 4'h0;
    else if (dir_state != URFC_DIR_WAIT) turn_cnt <= 4'h0; // R23
    else if (i_bit_tick && turn_cnt != 4'hf) turn_cnt <= turn_cnt + 4'h1; // R23
  end

  // Handshake outputs: RS-485 wins over auto flow control, select picks the pin
  wire dir_tx   = dir_state != URFC_DIR_RX;
  wire auto_rts = enhanced_feature_reg[`URFC_ENH_AUTORTS];
  wire sel_dtr  = modem_control_reg[`URFC_MCR_SEL];
  // In RS-485 mode the pin sits high while sending and low while receiving
  wire hs_n     = rs485 ? dir_tx : (auto_rts ? flow_hold : 1'b1); // R13 R15 R22
  assign o_rts_n = (rs485 || auto_rts) && !sel_dtr ? hs_n : ~modem_control_reg[1]; // R14
  assign o_dtr_n = (rs485 || auto_rts) && sel_dtr ? hs_n : ~modem_control_reg[0]; // R14
  assign o_tx_irq_src = rs485 ? (i_tsr_empty && i_tx_fifo_empty) : i_tx_fifo_empty; // R16

  // Checks
  a_delta_set: assert property (@(posedge i_mclk) disable iff (i_rst)
    cts_edge |=> delta_cts) else $error("delta cts not set"); // R1
  a_tune_lock: assert property (@(posedge i_mclk) disable iff (i_rst)
    (wr_tune && !enh_wren) |=> $stable(line_tune[7:4])) else $error("delay written while locked"); // R3
  a_scratch_wr: assert property (@(posedge i_mclk) disable iff (i_rst)
    wr_spr |=> scratch_pad == $past(i_wdata)) else $error("scratch lost write"); // R11
  a_rs485_wins: assert property (@(posedge i_mclk) disable iff (i_rst)
    (rs485 && !sel_dtr) |-> o_rts_n == dir_tx) else $error("rs485 not on rts"); // R13
  a_dir_rise: assert property (@(posedge i_mclk) disable iff (i_rst)
    (rs485 && $past(rs485) && i_tx_load) |=> dir_tx) else $error("direction not raised"); // R15
  a_tx_irq: assert property (@(posedge i_mclk) disable iff (i_rst)
    (rs485 && !i_tsr_empty) |-> !o_tx_irq_src) else $error("tx irq early"); // R16
  a_ir_pol: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_rx_ir == (ir_s ^ feature_control_reg[4])) else $error("ir polarity wrong"); // R18
  a_rx_block: assert property (@(posedge i_mclk) disable iff (i_rst)
    (rx_dis && !i_rx_busy) |-> !o_rx_accept) else $error("receive while disabled"); // R6
  a_tx_halt: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_tx_halt == line_tune[3]) else $error("tx halt mismatch"); // R4

  // Steps of the direction machine, shared by the properties below
  sequence s_wait_load;
    rs485 && (dir_state == URFC_DIR_WAIT) && i_tx_load;
  endsequence
  sequence s_back_to_tx;
    (dir_state == URFC_DIR_TX) ##1 (turn_cnt == 4'h0);
  endsequence
  sequence s_drained;
    rs485 && (dir_state == URFC_DIR_TX) && i_tsr_empty && i_tx_fifo_empty && !i_tx_load;
  endsequence
  sequence s_wait_run;
    rs485 && (dir_state == URFC_DIR_WAIT) && !i_tx_load && (turn_cnt != line_tune[7:4]);
  endsequence

  // A status read with no new change clears the flag
  a_delta_clear: assert property (@(posedge i_mclk) disable iff (i_rst) // R1
    (rd_status && !cts_edge)
    |=> !delta_cts) else $error("delta cts not cleared");

  // No interrupt without a pending change
  a_msi_quiet: assert property (@(posedge i_mclk) disable iff (i_rst) // R1
    !delta_cts
    |-> !o_msi_irq) else $error("modem irq without change");

  // Delay field takes the write while unlocked
  a_tune_open: assert property (@(posedge i_mclk) disable iff (i_rst) // R3
    (wr_tune && enh_wren)
    |=> line_tune[7:4] == $past(i_wdata[7:4])) else $error("delay write lost");

  // Enhanced modem control bits hold while locked
  a_mcr_lock: assert property (@(posedge i_mclk) disable iff (i_rst) // R21
    (wr_mcr && !enh_wren)
    |=> $stable(modem_control_reg[7:5])) else $error("modem ctl written while locked");

  // Enhanced interrupt enable bits hold while locked
  a_ier_lock: assert property (@(posedge i_mclk) disable iff (i_rst) // R21
    (wr_ier && !enh_wren)
    |=> $stable(interrupt_enable_reg[7:5])) else $error("irq enable written while locked");

  // Disabled transmitter in mode 0 lets no fresh xon/xoff out
  a_xchar_block: assert property (@(posedge i_mclk) disable iff (i_rst) // R9
    (tx_dis && !line_tune[`URFC_LT_TXMODE] && !xchar_pend)
    |-> !o_xchar_ok) else $error("xchar sent while disabled");

  // Mode 1 keeps xon/xoff going out
  a_xchar_mode: assert property (@(posedge i_mclk) disable iff (i_rst) // R9
    (tx_dis && line_tune[`URFC_LT_TXMODE])
    |-> o_xchar_ok) else $error("xchar blocked in mode 1");

  // Disabled receiver in mode 1 still acts on xon/xoff
  a_rx_mode: assert property (@(posedge i_mclk) disable iff (i_rst) // R10
    (rx_dis && line_tune[`URFC_LT_RXMODE])
    |-> o_rx_xchar_ok) else $error("rx xchar ignored in mode 1");

  // Disabled receiver in mode 0 ignores flow-control characters too
  a_rx_ignore: assert property (@(posedge i_mclk) disable iff (i_rst) // R10
    (rx_dis && !line_tune[`URFC_LT_RXMODE] && !i_rx_busy)
    |-> !o_rx_xchar_ok) else $error("rx xchar taken in mode 0");

  // Enabled receiver always accepts
  a_rx_open: assert property (@(posedge i_mclk) disable iff (i_rst) // R7
    !rx_dis
    |-> o_rx_accept) else $error("receiver blocked while enabled");

  // Upper level reached sets the hold
  a_flow_up: assert property (@(posedge i_mclk) disable iff (i_rst) // R22
    (i_rx_level >= up_lvl)
    |=> flow_hold) else $error("flow hold not set");

  // Below the lower level releases the hold
  a_flow_down: assert property (@(posedge i_mclk) disable iff (i_rst) // R22
    ((i_rx_level < dn_lvl) && (i_rx_level < up_lvl))
    |=> !flow_hold) else $error("flow hold not released");

  // Auto flow control drives the RTS pin when it is selected
  a_flow_pin: assert property (@(posedge i_mclk) disable iff (i_rst) // R14
    (auto_rts && !rs485 && !sel_dtr)
    |-> o_rts_n == flow_hold) else $error("flow hold not on rts");

  // Direction on the data terminal pin when selected
  a_dtr_dir: assert property (@(posedge i_mclk) disable iff (i_rst) // R14
    (rs485 && sel_dtr)
    |-> (o_dtr_n == dir_tx) && (o_rts_n == !modem_control_reg[1])) else $error("direction pin select wrong");

  // Tables A to C use the next trigger levels
  a_table_abc: assert property (@(posedge i_mclk) disable iff (i_rst) // R12
    !tbl_d
    |-> (up_lvl == i_next_up) && (dn_lvl == i_next_dn)) else $error("next levels not used");

  // Table D with code zero falls back to the next upper level
  a_hyst_zero: assert property (@(posedge i_mclk) disable iff (i_rst) // R19
    (tbl_d && (feature_control_reg[3:0] == 4'h0))
    |-> up_lvl == i_next_up) else $error("zero hysteresis misused");

  // Two spot values of the hysteresis decode
  a_hyst_val: assert property (@(posedge i_mclk) disable iff (i_rst) // R20
    (feature_control_reg[3:0] == 4'hb)
    |-> hv == 6'd52) else $error("hysteresis decode wrong");
  a_hyst_low: assert property (@(posedge i_mclk) disable iff (i_rst) // R20
    (feature_control_reg[3:0] == 4'hc)
    |-> hv == 6'd12) else $error("hysteresis decode wrong");

  // Direction stays on transmit until the delay runs out
  a_wait_hold: assert property (@(posedge i_mclk) disable iff (i_rst) // R2
    s_wait_run
    |=> dir_tx) else $error("direction dropped early");

  // Delay reached switches to receive
  a_wait_end: assert property (@(posedge i_mclk) disable iff (i_rst) // R2
    (rs485 && (dir_state == URFC_DIR_WAIT) && !i_tx_load && (turn_cnt == line_tune[7:4]))
    |=> !dir_tx) else $error("direction held too long");

  // Each bit tick advances the turn-around count
  a_tick_count: assert property (@(posedge i_mclk) disable iff (i_rst) // R23
    (s_wait_run and i_bit_tick)
    |=> turn_cnt == $past(turn_cnt) + 4'h1) else $error("turn count missed tick");

  // A byte during the delay restarts the count
  a_load_restart: assert property (@(posedge i_mclk) disable iff (i_rst) // R23
    s_wait_load
    |=> s_back_to_tx) else $error("count not restarted");

  // Drained transmitter starts the turn-around
  a_drain: assert property (@(posedge i_mclk) disable iff (i_rst) // R15
    s_drained
    |=> dir_state == URFC_DIR_WAIT) else $error("turn-around not started");

  // A lone flow-control character never turns the line
  a_xchar_no_dir: assert property (@(posedge i_mclk) disable iff (i_rst) // R17
    (rs485 && (dir_state == URFC_DIR_RX) && !i_tx_load)
    |=> !dir_tx) else $error("direction moved without load");

  // Legacy mode signals on holding empty alone
  a_tx_irq_legacy: assert property (@(posedge i_mclk) disable iff (i_rst) // R16
    (!rs485 && i_tx_fifo_empty)
    |-> o_tx_irq_src) else $error("tx irq late in legacy mode");

  // Scratch read returns the stored byte one cycle later
  a_scratch_rd: assert property (@(posedge i_mclk) disable iff (i_rst) // R11
    (i_rd && (i_addr == `URFC_ADDR_SCRATCH))
    |=> o_rdata == $past(scratch_pad)) else $error("scratch read wrong");
endmodule

// ===== verif/urfc_line_model.sv
// Far-side partner of the feature block: bit-time source and the remote's modem and receive pins.
// Assumes: shares the bench clock; the bench chooses the pin levels through the request inputs.
`timescale 1ns/1ps
module urfc_line_model #(
  parameter int DIV = 8
) (
  input  wire logic i_mclk,
  input  wire logic i_rst,
  input  wire logic i_cts_req,
  input  wire logic i_ir_req,
  output logic      o_tick,
  output logic      o_cts_n,
  output logic      o_rx_ir
);
  int cnt;
  // Free-running bit clock; the turn-around delay is counted in these
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnt <= 0;
      o_tick <= 1'b0;
    end else begin
      cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
      o_tick <= (cnt == DIV - 1);
    end
  end
  // Remote pins are driven levels, never left floating
  assign o_cts_n = i_cts_req;
  assign o_rx_ir = i_ir_req;
endmodule

// ===== verif/urfc_ctrl_tb.sv
// Self-checking bench for the UART feature control block.
// Assumes: the line model supplies bit ticks; the bench plays host software and the shifters.
`timescale 1ns/1ps
module urfc_ctrl_tb;
  logic clk = 0, rst = 1, wr = 0, rd = 0, load = 0, xchar = 0, fifo_e = 1, tsr_e = 1, busy = 0;
  logic cts_q = 1, ir_q = 0, rts_n, dtr_n, tick, cts_n, rx_ir, halt, xok, racc, rxok, irx, txirq, msi;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, got;
  logic [8:0] lvl = 9'h000, trig = 9'h040, nup = 9'h064, ndn = 9'h002;
  int n_fail = 0, total_checks = 0;
  int hy[16] = '{0, 4, 6, 8, 8, 16, 24, 32, 40, 44, 48, 52, 12, 20, 28, 36};
  // 25 MHz clock
  always #20 clk = ~clk;
  urfc_ctrl urfc_ctrl_inst (.i_mclk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_cts_n(cts_n), .i_rx_ir(rx_ir), .o_rts_n(rts_n), .o_dtr_n(dtr_n), .i_bit_tick(tick),
    .i_tx_load(load), .i_tx_xchar(xchar), .i_tx_fifo_empty(fifo_e), .i_tsr_empty(tsr_e), .i_rx_busy(busy),
    .i_rx_level(lvl), .i_rx_trigger(trig), .i_next_up(nup), .i_next_dn(ndn), .o_tx_halt(halt),
    .o_xchar_ok(xok), .o_rx_accept(racc), .o_rx_xchar_ok(rxok), .o_rx_ir(irx), .o_tx_irq_src(txirq),
    .o_msi_irq(msi));
  urfc_line_model urfc_line_model_inst (.i_mclk(clk), .i_rst(rst), .i_cts_req(cts_q), .i_ir_req(ir_q),
    .o_tick(tick), .o_cts_n(cts_n), .o_rx_ir(rx_ir));
  task automatic finish_test;
    $display("checks=%0d failures=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk({7'h00, g}, {7'h00, e});
  endtask
  // Settle point: mid-cycle, away from the sampling edge
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rreg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    got = rdata;
  endtask
  // Bounded wait for one bit tick
  task automatic wtick;
    int i;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (tick !== 1'b1 && i < 64);
    if (i >= 64) begin
      n_fail++;
      finish_test();
    end
  endtask
  // One byte loaded, shifted out, both stages empty afterwards
  task automatic tx_byte;
    @(posedge clk);
    load <= 1'b1;
    fifo_e <= 1'b0;
    tsr_e <= 1'b0;
    @(posedge clk);
    load <= 1'b0;
    @(posedge clk);
    fifo_e <= 1'b1;
    tsr_e <= 1'b1;
  endtask
  task automatic t_reg;
    rreg(4'h1);
    chk(got, 8'hff);
    rreg(4'h2);
    chk(got, 8'h00);
    rreg(4'h7);
    chk(got, 8'h00);
    wreg(4'h1, 8'h5a);
    rreg(4'h1);
    chk(got, 8'h5a);
  endtask
  task automatic t_cts;
    rreg(4'h5);
    wreg(4'h6, 8'h08);
    cyc(2);
    chk1(msi, 1'b0);
    @(posedge clk);
    cts_q <= 1'b0;
    cyc(5);
    chk1(msi, 1'b1);
    rreg(4'h5);
    chk(got, 8'h81);
    rreg(4'h5);
    chk(got, 8'h80);
    wreg(4'h6, 8'h00);
    @(posedge clk);
    cts_q <= 1'b1;
    cyc(5);
    chk1(msi, 1'b0);
    rreg(4'h5);
    chk(got, 8'h01);
  endtask
  task automatic t_dis;
    wreg(4'h3, 8'h10);
    @(posedge clk);
    busy <= 1'b1;
    wreg(4'h0, 8'h0c);
    cyc(2);
    chk({4'h0, halt, racc, xok, rxok}, 8'h0d);
    @(posedge clk);
    busy <= 1'b0;
    cyc(2);
    chk1(racc, 1'b0);
    wreg(4'h0, 8'h0f);
    cyc(2);
    chk({6'h00, xok, rxok}, 8'h03);
    wreg(4'h0, 8'h00);
    @(posedge clk);
    xchar <= 1'b1;
    wreg(4'h0, 8'h08);
    cyc(2);
    chk1(xok, 1'b1);
    wreg(4'h0, 8'h00);
    xchar <= 1'b0;
    cyc(2);
    chk({6'h00, halt, racc}, 8'h01);
  endtask
  task automatic t_ir;
    @(posedge clk);
    ir_q <= 1'b1;
    cyc(5);
    chk1(irx, 1'b1);
    wreg(4'h2, 8'h10);
    cyc(2);
    chk1(irx, 1'b0);
  endtask
  task automatic t_dir;
    wreg(4'h3, 8'h10);
    wreg(4'h0, 8'h30);
    wreg(4'h3, 8'h00);
    wreg(4'h0, 8'hf0);
    wreg(4'h2, 8'h20);
    @(posedge clk);
    tsr_e <= 1'b0;
    cyc(2);
    chk({6'h00, rts_n, txirq}, 8'h00);
    tx_byte();
    cyc(1);
    chk1(rts_n, 1'b1);
    wtick();
    wtick();
    cyc(3);
    chk1(rts_n, 1'b1);
    wtick();
    cyc(3);
    chk1(rts_n, 1'b0);
    wreg(4'h4, 8'h04);
    tx_byte();
    cyc(1);
    wtick();
    wtick();
    tx_byte();
    cyc(1);
    wtick();
    wtick();
    cyc(3);
    chk({6'h00, rts_n, dtr_n}, 8'h03);
    wtick();
    cyc(3);
    chk({6'h00, rts_n, dtr_n}, 8'h02);
  endtask
  task automatic t_flow;
    wreg(4'h3, 8'h50);
    wreg(4'h4, 8'h02);
    for (int c = 1; c < 16; c++) begin
      wreg(4'h2, 8'hc0 | 8'(c));
      lvl <= 9'(64 + hy[c] + 1);
      cyc(3);
      chk1(rts_n, 1'b1);
      @(posedge clk);
      lvl <= 9'(64 - hy[c] - 1);
      cyc(3);
      chk1(rts_n, 1'b0);
    end
    chk1(txirq, 1'b1);
    wreg(4'h2, 8'h01);
    lvl <= 9'h050;
    cyc(3);
    chk1(rts_n, 1'b0);
    @(posedge clk);
    lvl <= 9'h065;
    cyc(3);
    chk1(rts_n, 1'b1);
    wreg(4'h2, 8'h21);
    cyc(3);
    chk1(rts_n, 1'b0);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reg();
    t_cts();
    t_dis();
    t_ir();
    t_dir();
    t_flow();
    finish_test();
  end
endmodule
